// ---- core/inp_pkg.sv ----
package inp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 9;
  localparam int SAMPLE_W = 24;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [6:0] OFS_PWR_ONE    = 7'h01;
  localparam logic [6:0] OFS_PWR_TWO    = 7'h02;
  localparam logic [6:0] OFS_RATE       = 7'h07;
  localparam logic [6:0] OFS_FILTER     = 7'h0e;
  localparam logic [6:0] OFS_LOOP_ONE   = 7'h20;
  localparam logic [6:0] OFS_ROUTING    = 7'h2c;
  localparam logic [6:0] OFS_GAIN       = 7'h2d;
  localparam logic [6:0] OFS_BOOST      = 7'h2f;
  localparam logic [6:0] OFS_BIAS_MODE  = 7'h3a;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [8:0] RST_PWR_ONE    = 9'h000;
  localparam logic [8:0] RST_PWR_TWO    = 9'h000;
  localparam logic [8:0] RST_RATE       = 9'h000;
  localparam logic [8:0] RST_FILTER     = 9'h000;
  localparam logic [8:0] RST_LOOP_ONE   = 9'h038;
  localparam logic [8:0] RST_ROUTING    = 9'h000;
  localparam logic [8:0] RST_GAIN       = 9'h010;
  localparam logic [8:0] RST_BOOST      = 9'h000;
  localparam logic [8:0] RST_BIAS_MODE  = 9'h000;
  localparam logic [9:0] RST_BIAS_MILLI = 10'h384;
  localparam logic [9:0] RST_CUTOFF_HZ  = 10'h07a;

  ////////////////////////////////////////////////////////////////////////////////
  // Writable bits of each register; all others read zero
  localparam logic [8:0] MASK_PWR_ONE   = 9'h010;
  localparam logic [8:0] MASK_PWR_TWO   = 9'h015;
  localparam logic [8:0] MASK_RATE      = 9'h00e;
  localparam logic [8:0] MASK_FILTER    = 9'h1f9;
  localparam logic [8:0] MASK_LOOP_ONE  = 9'h13f;
  localparam logic [8:0] MASK_ROUTING   = 9'h187;
  localparam logic [8:0] MASK_GAIN      = 9'h0ff;
  localparam logic [8:0] MASK_BOOST     = 9'h177;
  localparam logic [8:0] MASK_BIAS_MODE = 9'h010;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int POS_BIAS_ENABLE    = 4;
  localparam int POS_CONV_ENABLE    = 0;
  localparam int POS_AMP_ENABLE     = 2;
  localparam int POS_BOOST_ENABLE   = 4;
  localparam int POS_RATE_LSB       = 1;
  localparam int POS_POLARITY       = 0;
  localparam int POS_OVERSAMPLE     = 3;
  localparam int POS_CUTOFF_LSB     = 4;
  localparam int POS_HP_MODE        = 7;
  localparam int POS_HP_ENABLE      = 8;
  localparam int POS_LOOP_ENABLE    = 8;
  localparam int POS_NONINV_SEL     = 0;
  localparam int POS_INV_SEL        = 1;
  localparam int POS_LINE_TO_AMP    = 2;
  localparam int POS_BIAS_LVL_LSB   = 7;
  localparam int POS_GAIN_LSB       = 0;
  localparam int POS_MUTE           = 6;
  localparam int POS_ZERO_CROSS     = 7;
  localparam int POS_LINE_BOOST_LSB = 0;
  localparam int POS_NI_BOOST_LSB   = 4;
  localparam int POS_AMP_BOOST      = 8;
  localparam int POS_BIAS_MODE      = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Gain arithmetic: amplifier in quarter dB, boost paths in dB
  localparam logic [8:0] GAIN_MIN_QDB   = 9'h1d0;
  localparam logic [8:0] GAIN_STEP_QDB  = 9'h003;
  localparam logic [4:0] BOOST_OFS_DB   = 5'h0f;
  localparam logic [4:0] BOOST_STEP_DB  = 5'h03;
  localparam logic [4:0] AMP_BOOST_DB   = 5'h14;
  localparam logic [7:0] OSR_LOW        = 8'h40;
  localparam logic [7:0] OSR_HIGH       = 8'h80;

  // Bias level in thousandths of supply, indexed by {mode, level code}
  localparam logic [7:0][9:0] BIAS_MILLI = {
    10'h1f4, 10'h2bc, 10'h258, 10'h352,
    10'h1f4, 10'h2ee, 10'h28a, 10'h384
  };

endpackage

// ---- core/inp_hpf_cutoff.sv ----
`timescale 1ns/1ps

module inp_hpf_cutoff (
  input  wire logic [2:0] cutoffSel,
  input  wire logic [2:0] rateSel,
  input  wire logic       frac441Clock,
  output logic      [9:0] cutoffHz
);

  // Cutoff for each rate family; the rate pair shares one column
  always_comb begin
    cutoffHz = 10'h000;
    if (frac441Clock) begin
      unique case (cutoffSel)
        3'h0: cutoffHz = 10'h071;
        3'h1: cutoffHz = 10'h08d;
        3'h2: cutoffHz = 10'h0b4;
        3'h3: cutoffHz = 10'h0e1;
        3'h4: cutoffHz = 10'h119;
        3'h5: cutoffHz = 10'h168;
        3'h6: cutoffHz = 10'h1c2;
        3'h7: cutoffHz = 10'h233;
      endcase
    end else if (rateSel[0]) begin
      unique case (cutoffSel)
        3'h0: cutoffHz = 10'h052;
        3'h1: cutoffHz = 10'h066;
        3'h2: cutoffHz = 10'h083;
        3'h3: cutoffHz = 10'h0a3;
        3'h4: cutoffHz = 10'h0cc;
        3'h5: cutoffHz = 10'h105;
        3'h6: cutoffHz = 10'h147;
        3'h7: cutoffHz = 10'h198;
      endcase
    end else begin
      unique case (cutoffSel)
        3'h0: cutoffHz = 10'h07a;
        3'h1: cutoffHz = 10'h099;
        3'h2: cutoffHz = 10'h09c;
        3'h3: cutoffHz = 10'h0f5;
        3'h4: cutoffHz = 10'h132;
        3'h5: cutoffHz = 10'h188;
        3'h6: cutoffHz = 10'h1ea;
        3'h7: cutoffHz = 10'h264;
      endcase
    end
  end

endmodule // inp_hpf_cutoff

// ---- core/inp_adc_control.sv ----
//
// Contract
// - Inverting select bit connects inverting voice input to amplifier negative terminal.
// - Line-to-amp bit mixes line input into inverting amplifier path.
// - Shared gain amplifier enabled only while its power bit is set.
// - Six-bit gain field sets -12 to +35.25 dB in 0.75 dB steps.
// - Level loop enable overrides software gain with loop gain.
// - Boost stage and mixer powered only while boost enable is high.
// - Line boost code zero disconnects; others give -12 to +6 dB, 3 dB steps.
// - Mute bit disconnects amplifier output from boost mixer.
// - Amplifier path boost bit gives +20 dB, else 0 dB.
// - Non-inverting boost code zero disconnects; others -12 to +6 dB.
// - Capsule bias output enabled only while its enable bit is high.
// - Bias mode 0 codes give 0.9, 0.65, 0.75, 0.5 of supply.
// - Bias mode 1 codes give 0.85, 0.60, 0.70, 0.50 of supply.
// - Converter enabled only while its enable bit is set.
// - Polarity bit inverts sign of output samples.
// - Oversample bit selects 64x when clear, 128x when set.
// - High-pass active only when enabled; mode selects first or second order.
// - Second-order cutoff from cutoff field, scaled by sample rate field.
// - 24-bit chain ends here; output words are two's complement.
// - Non-inverting select ties positive terminal to voice input, else mid reference.
//
`timescale 1ns/1ps

module inp_adc_control #(
  parameter int SAMPLE_W = inp_pkg::SAMPLE_W
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Register port from the serial control interface
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  input  wire logic [inp_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [inp_pkg::DATA_W-1:0] regWrData,
  output logic      [inp_pkg::DATA_W-1:0] regRdData,
  output logic                           regRdValid,
  // Level loop and clock configuration, same clock domain
  input  wire logic [5:0]                loopGain,
  input  wire logic                      frac441Clock,
  // Samples from the notch filter stage
  input  wire logic [SAMPLE_W-1:0]       sampleIn,
  input  wire logic                      sampleInValid,
  output logic      [SAMPLE_W-1:0]       sampleOut,
  output logic                           sampleOutValid,
  // Input amplifier controls
  output logic                           invInputConnect,
  output logic                           noninvInputConnect,
  output logic                           midRefToPositive,
  output logic                           lineToAmpConnect,
  output logic                           gainAmpEnable,
  output logic      [5:0]                gainAmpLevel,
  output logic      [8:0]                gainAmpQdb,
  output logic                           gainZeroCross,
  // Boost stage controls
  output logic                           boostStageEnable,
  output logic                           ampToMixerConnect,
  output logic      [4:0]                ampPathBoostDb,
  output logic                           lineBoostConnect,
  output logic      [4:0]                lineBoostDb,
  output logic                           noninvBoostConnect,
  output logic      [4:0]                noninvBoostDb,
  // Capsule bias controls
  output logic                           capsuleBiasEnable,
  output logic      [9:0]                biasRatioMilli,
  // Converter controls
  output logic                           converterEnable,
  output logic      [7:0]                oversampleRatio,
  output logic                           highpassEnable,
  output logic                           highpassSecondOrder,
  output logic      [9:0]                highpassCutoffHz
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Register fields
    logic [8:0]          rPwrOne;
    logic [8:0]          rPwrTwo;
    logic [8:0]          rRate;
    logic [8:0]          rFilter;
    logic [8:0]          rLoopOne;
    logic [8:0]          rRouting;
    logic [8:0]          rGain;
    logic [8:0]          rBoost;
    logic [8:0]          rBiasMode;
    // Read port
    logic [8:0]          rdData;
    logic                rdValid;
    // Samples
    logic [SAMPLE_W-1:0] sample;
    logic                sampleValid;
    // Input amplifier
    logic                invConn;
    logic                niConn;
    logic                midRef;
    logic                lineAmp;
    logic                ampEn;
    logic [5:0]          ampLevel;
    logic [8:0]          ampQdb;
    logic                zeroCross;
    // Boost stage
    logic                boostEn;
    logic                ampMixConn;
    logic [4:0]          ampBoost;
    logic                lineConn;
    logic [4:0]          lineDb;
    logic                niBoostConn;
    logic [4:0]          niDb;
    // Capsule bias
    logic                biasEn;
    logic [9:0]          biasMilli;
    // Converter
    logic                convEn;
    logic [7:0]          osr;
    logic                hpEn;
    logic                hpSecond;
    logic [9:0]          hpCutoff;
  } inp_state_s;

  // Registered copy and next value
  inp_state_s state_r;
  inp_state_s state_nxt;

  // Lookup result, fed into state_nxt
  logic [9:0] cutoffHz;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Code 0 gives -48 quarter dB
  // Amplifier gain code to quarter dB, two's complement
  function automatic logic [8:0] gain_qdb(input logic [5:0] code);
    logic [8:0] prod;
    prod = 9'({3'h0, code} * inp_pkg::GAIN_STEP_QDB);
    return prod + inp_pkg::GAIN_MIN_QDB;
  endfunction

  // Boost code 1..7 to dB in 3 dB steps, two's complement
  function automatic logic [4:0] boost_db(input logic [2:0] code);
    logic [4:0] prod;
    prod = 5'({2'h0, code} * inp_pkg::BOOST_STEP_DB);
    return (code == 3'h0) ? 5'h00 : prod - inp_pkg::BOOST_OFS_DB;
  endfunction

  // Plain negation wraps the minimum
  // Sign inversion that keeps the most negative code in range
  function automatic logic [SAMPLE_W-1:0] neg_sat(input logic [SAMPLE_W-1:0] x);
    logic [SAMPLE_W-1:0] minVal;
    minVal = {1'b1, {(SAMPLE_W-1){1'b0}}};
    return (x == minVal) ? ~minVal : (~x + {{(SAMPLE_W-1){1'b0}}, 1'b1});
  endfunction

  // Register read decode; unmapped offsets read zero
  function automatic logic [8:0] read_reg(input inp_state_s s, input logic [6:0] a);
    logic [8:0] d;
    d = 9'h000;
    case (a)
      inp_pkg::OFS_PWR_ONE:   d = s.rPwrOne;
      inp_pkg::OFS_PWR_TWO:   d = s.rPwrTwo;
      inp_pkg::OFS_RATE:      d = s.rRate;
      inp_pkg::OFS_FILTER:    d = s.rFilter;
      inp_pkg::OFS_LOOP_ONE:  d = s.rLoopOne;
      inp_pkg::OFS_ROUTING:   d = s.rRouting;
      inp_pkg::OFS_GAIN:      d = s.rGain;
      inp_pkg::OFS_BOOST:     d = s.rBoost;
      inp_pkg::OFS_BIAS_MODE: d = s.rBiasMode;
      default:                d = 9'h000;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Cutoff lookup for second-order high-pass
  // Reads stored fields and the frac441Clock input only, no loop

  inp_hpf_cutoff u_cutoff (
    .cutoffSel    (state_nxt.rFilter[inp_pkg::POS_CUTOFF_LSB +: 3]),
    .rateSel      (state_nxt.rRate[inp_pkg::POS_RATE_LSB +: 3]),
    .frac441Clock (frac441Clock),
    .cutoffHz     (cutoffHz)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    // Hold all; pulses clear
    state_nxt             = state_r;
    state_nxt.rdValid     = 1'b0;
    state_nxt.sampleValid = 1'b0;

    // Read answers with the value held before any same-cycle write
    if (regRead) begin
      state_nxt.rdValid = 1'b1;
      state_nxt.rdData  = read_reg(state_r, regAddr);
    end

    // Masked writes; fields hold otherwise, reserved bits stay zero
    if (regWrite) begin
      case (regAddr)
        inp_pkg::OFS_PWR_ONE:   state_nxt.rPwrOne   = regWrData & inp_pkg::MASK_PWR_ONE;
        inp_pkg::OFS_PWR_TWO:   state_nxt.rPwrTwo   = regWrData & inp_pkg::MASK_PWR_TWO;
        inp_pkg::OFS_RATE:      state_nxt.rRate     = regWrData & inp_pkg::MASK_RATE;
        inp_pkg::OFS_FILTER:    state_nxt.rFilter   = regWrData & inp_pkg::MASK_FILTER;
        inp_pkg::OFS_LOOP_ONE:  state_nxt.rLoopOne  = regWrData & inp_pkg::MASK_LOOP_ONE;
        inp_pkg::OFS_ROUTING:   state_nxt.rRouting  = regWrData & inp_pkg::MASK_ROUTING;
        inp_pkg::OFS_GAIN:      state_nxt.rGain     = regWrData & inp_pkg::MASK_GAIN;
        inp_pkg::OFS_BOOST:     state_nxt.rBoost    = regWrData & inp_pkg::MASK_BOOST;
        inp_pkg::OFS_BIAS_MODE: state_nxt.rBiasMode = regWrData & inp_pkg::MASK_BIAS_MODE;
        default: ;
      endcase
    end

    // Derived fields read state_nxt
    // Input selection follows the routing register at the write edge
    state_nxt.invConn = state_nxt.rRouting[inp_pkg::POS_INV_SEL];
    state_nxt.niConn  = state_nxt.rRouting[inp_pkg::POS_NONINV_SEL];
    state_nxt.midRef  = ~state_nxt.rRouting[inp_pkg::POS_NONINV_SEL];
    state_nxt.lineAmp = state_nxt.rRouting[inp_pkg::POS_LINE_TO_AMP];

    // Amplifier power, gain source and zero-cross flag
    state_nxt.ampEn = state_nxt.rPwrTwo[inp_pkg::POS_AMP_ENABLE];
    if (state_nxt.rLoopOne[inp_pkg::POS_LOOP_ENABLE]) begin
      state_nxt.ampLevel = loopGain;
    end else begin
      state_nxt.ampLevel = state_nxt.rGain[inp_pkg::POS_GAIN_LSB +: 6];
    end
    state_nxt.ampQdb    = gain_qdb(state_nxt.ampLevel);
    state_nxt.zeroCross = state_nxt.rGain[inp_pkg::POS_ZERO_CROSS];

    // Boost stage and its three mixer inputs
    state_nxt.boostEn    = state_nxt.rPwrTwo[inp_pkg::POS_BOOST_ENABLE];
    state_nxt.ampMixConn = ~state_nxt.rGain[inp_pkg::POS_MUTE];
    state_nxt.ampBoost   = state_nxt.rBoost[inp_pkg::POS_AMP_BOOST] ?
                           inp_pkg::AMP_BOOST_DB : 5'h00;
    state_nxt.lineConn   = |state_nxt.rBoost[inp_pkg::POS_LINE_BOOST_LSB +: 3];
    state_nxt.lineDb     = boost_db(state_nxt.rBoost[inp_pkg::POS_LINE_BOOST_LSB +: 3]);
    state_nxt.niBoostConn = |state_nxt.rBoost[inp_pkg::POS_NI_BOOST_LSB +: 3];
    state_nxt.niDb       = boost_db(state_nxt.rBoost[inp_pkg::POS_NI_BOOST_LSB +: 3]);

    // Capsule bias enable and level
    // Index is {mode, level code}
    state_nxt.biasEn    = state_nxt.rPwrOne[inp_pkg::POS_BIAS_ENABLE];
    state_nxt.biasMilli = inp_pkg::BIAS_MILLI[{state_nxt.rBiasMode[inp_pkg::POS_BIAS_MODE],
                          state_nxt.rRouting[inp_pkg::POS_BIAS_LVL_LSB +: 2]}];

    // Converter enable, oversampling and high-pass configuration
    // Cutoff valid in any mode
    state_nxt.convEn   = state_nxt.rPwrTwo[inp_pkg::POS_CONV_ENABLE];
    state_nxt.osr      = state_nxt.rFilter[inp_pkg::POS_OVERSAMPLE] ?
                         inp_pkg::OSR_HIGH : inp_pkg::OSR_LOW;
    state_nxt.hpEn     = state_nxt.rFilter[inp_pkg::POS_HP_ENABLE];
    state_nxt.hpSecond = state_nxt.rFilter[inp_pkg::POS_HP_MODE];
    state_nxt.hpCutoff = cutoffHz;

    // Final sample stage: polarity on two's complement words
    // Uses state_r: same-cycle write waits
    if (sampleInValid && state_r.rPwrTwo[inp_pkg::POS_CONV_ENABLE]) begin
      state_nxt.sampleValid = 1'b1;
      if (state_r.rFilter[inp_pkg::POS_POLARITY]) begin
        state_nxt.sample = neg_sat(sampleIn);
      end else begin
        state_nxt.sample = sampleIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r             <= '0;
      // Stored fields
      state_r.rPwrOne     <= inp_pkg::RST_PWR_ONE;
      state_r.rPwrTwo     <= inp_pkg::RST_PWR_TWO;
      state_r.rRate       <= inp_pkg::RST_RATE;
      state_r.rFilter     <= inp_pkg::RST_FILTER;
      state_r.rLoopOne    <= inp_pkg::RST_LOOP_ONE;
      state_r.rRouting    <= inp_pkg::RST_ROUTING;
      state_r.rGain       <= inp_pkg::RST_GAIN;
      state_r.rBoost      <= inp_pkg::RST_BOOST;
      state_r.rBiasMode   <= inp_pkg::RST_BIAS_MODE;
      // Outputs matching those fields
      state_r.midRef      <= 1'b1;
      state_r.ampMixConn  <= 1'b1;
      state_r.ampLevel    <= inp_pkg::RST_GAIN[5:0];
      state_r.ampQdb      <= 9'h000;
      state_r.biasMilli   <= inp_pkg::RST_BIAS_MILLI;
      state_r.osr         <= inp_pkg::OSR_LOW;
      state_r.hpCutoff    <= inp_pkg::RST_CUTOFF_HZ;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register

  // Read port
  assign regRdData           = state_r.rdData;
  assign regRdValid          = state_r.rdValid;

  // Samples
  assign sampleOut           = state_r.sample;
  assign sampleOutValid      = state_r.sampleValid;

  // Input amplifier
  assign invInputConnect     = state_r.invConn;
  assign noninvInputConnect  = state_r.niConn;
  assign midRefToPositive    = state_r.midRef;
  assign lineToAmpConnect    = state_r.lineAmp;
  assign gainAmpEnable       = state_r.ampEn;
  assign gainAmpLevel        = state_r.ampLevel;
  assign gainAmpQdb          = state_r.ampQdb;
  assign gainZeroCross       = state_r.zeroCross;

  // Boost stage
  assign boostStageEnable    = state_r.boostEn;
  assign ampToMixerConnect   = state_r.ampMixConn;
  assign ampPathBoostDb      = state_r.ampBoost;
  assign lineBoostConnect    = state_r.lineConn;
  assign lineBoostDb         = state_r.lineDb;
  assign noninvBoostConnect  = state_r.niBoostConn;
  assign noninvBoostDb       = state_r.niDb;

  // Capsule bias
  assign capsuleBiasEnable   = state_r.biasEn;
  assign biasRatioMilli      = state_r.biasMilli;

  // Converter
  assign converterEnable     = state_r.convEn;
  assign oversampleRatio     = state_r.osr;
  assign highpassEnable      = state_r.hpEn;
  assign highpassSecondOrder = state_r.hpSecond;
  assign highpassCutoffHz    = state_r.hpCutoff;

endmodule // inp_adc_control

// ---- sim/inp_adc_control_checker.sv ----
`timescale 1ns/1ps

module inp_adc_control_checker (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [8:0] regWrData,
  input wire logic [5:0] loopGain,
  input wire logic       sampleInValid,
  input wire logic       sampleOutValid,
  input wire logic       invInputConnect,
  input wire logic       noninvInputConnect,
  input wire logic       midRefToPositive,
  input wire logic       gainAmpEnable,
  input wire logic [5:0] gainAmpLevel,
  input wire logic [8:0] gainAmpQdb,
  input wire logic [4:0] ampPathBoostDb,
  input wire logic       capsuleBiasEnable
);
  logic loopOn_r;
  logic convOn_r;
  // Shadow of the loop and converter enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loopOn_r <= 1'b0;
      convOn_r <= 1'b0;
    end else if (regWrite && regAddr == 7'h20) begin
      loopOn_r <= regWrData[8];
    end else if (regWrite && regAddr == 7'h02) begin
      convOn_r <= regWrData[0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_inv; regWrite && regAddr == 7'h2c |=> invInputConnect == $past(regWrData[1]); endproperty
  a_inv: assert property (p_inv) else $error("inverting select wrong");
  property p_mid; midRefToPositive != noninvInputConnect; endproperty
  a_mid: assert property (p_mid) else $error("positive terminal wrong");
  property p_amp; regWrite && regAddr == 7'h02 |=> gainAmpEnable == $past(regWrData[2]); endproperty
  a_amp: assert property (p_amp) else $error("amplifier enable wrong");
  property p_qdb; gainAmpQdb + 9'd48 == 9'd3 * {3'h0, gainAmpLevel}; endproperty
  a_qdb: assert property (p_qdb) else $error("gain step wrong");
  property p_loop; loopOn_r |-> gainAmpLevel == $past(loopGain); endproperty
  a_loop: assert property (p_loop) else $error("loop gain not used");
  property p_boost;
    regWrite && regAddr == 7'h2f |=> ampPathBoostDb == ($past(regWrData[8]) ? 5'h14 : 5'h00);
  endproperty
  a_boost: assert property (p_boost) else $error("path boost wrong");
  property p_bias; regWrite && regAddr == 7'h01 |=> capsuleBiasEnable == $past(regWrData[4]); endproperty
  a_bias: assert property (p_bias) else $error("bias enable wrong");
  property p_smp; sampleOutValid == $past(sampleInValid && convOn_r); endproperty
  a_smp: assert property (p_smp) else $error("sample valid wrong");
  // Main scenarios reached
  c_loop: cover property (loopOn_r);
  c_smp: cover property (sampleOutValid);
  c_route: cover property (regWrite && regAddr == 7'h2c);
endmodule // inp_adc_control_checker

bind inp_adc_control inp_adc_control_checker inp_adc_control_checker_i (.clk_sys, .rst_n,
  .regWrite, .regAddr, .regWrData, .loopGain, .sampleInValid, .sampleOutValid,
  .invInputConnect, .noninvInputConnect, .midRefToPositive, .gainAmpEnable, .gainAmpLevel,
  .gainAmpQdb, .ampPathBoostDb, .capsuleBiasEnable);

// ---- sim/tb.sv ----
`timescale 1ns/1ps

module tb;
  logic clk_sys = 0, rst_n = 0, regWrite = 0, regRead = 0, frac441Clock = 0, sampleInValid = 0;
  logic [6:0] regAddr = 0;
  logic [8:0] regWrData = 0, regRdData, gainAmpQdb;
  logic [5:0] loopGain = 0, gainAmpLevel;
  logic [23:0] sampleIn = 0, sampleOut;
  logic regRdValid, sampleOutValid, invInputConnect, noninvInputConnect, midRefToPositive;
  logic lineToAmpConnect, gainAmpEnable, gainZeroCross, boostStageEnable, ampToMixerConnect;
  logic lineBoostConnect, noninvBoostConnect, capsuleBiasEnable, converterEnable;
  logic highpassEnable, highpassSecondOrder;
  logic [4:0] ampPathBoostDb, lineBoostDb, noninvBoostDb;
  logic [9:0] biasRatioMilli, highpassCutoffHz;
  logic [7:0] oversampleRatio;
  logic [8:0] m [0:127];
  logic [6:0] ofs [10] = '{7'h01, 7'h02, 7'h07, 7'h0e, 7'h20, 7'h2c, 7'h2d, 7'h2f, 7'h3a, 7'h05};
  int hz [3][8] = '{'{122, 153, 156, 245, 306, 392, 490, 612},
    '{82, 102, 131, 163, 204, 261, 327, 408}, '{113, 141, 180, 225, 281, 360, 450, 563}};
  int bias [8] = '{900, 650, 750, 500, 850, 600, 700, 500};
  int errors = 0, n_compared = 0, cyc = 0, col;
  logic [8:0] b;

  inp_adc_control inp_adc_control_i (.clk_sys, .rst_n, .regWrite, .regRead, .regAddr,
    .regWrData, .regRdData, .regRdValid, .loopGain, .frac441Clock, .sampleIn, .sampleInValid,
    .sampleOut, .sampleOutValid, .invInputConnect, .noninvInputConnect, .midRefToPositive,
    .lineToAmpConnect, .gainAmpEnable, .gainAmpLevel, .gainAmpQdb, .gainZeroCross,
    .boostStageEnable, .ampToMixerConnect, .ampPathBoostDb, .lineBoostConnect, .lineBoostDb,
    .noninvBoostConnect, .noninvBoostDb, .capsuleBiasEnable, .biasRatioMilli, .converterEnable,
    .oversampleRatio, .highpassEnable, .highpassSecondOrder, .highpassCutoffHz);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  function automatic logic [8:0] mask(input logic [6:0] a);
    case (a)
      7'h01: return inp_pkg::MASK_PWR_ONE;
      7'h02: return inp_pkg::MASK_PWR_TWO;
      7'h07: return inp_pkg::MASK_RATE;
      7'h0e: return inp_pkg::MASK_FILTER;
      7'h20: return inp_pkg::MASK_LOOP_ONE;
      7'h2c: return inp_pkg::MASK_ROUTING;
      7'h2d: return inp_pkg::MASK_GAIN;
      7'h2f: return inp_pkg::MASK_BOOST;
      7'h3a: return inp_pkg::MASK_BIAS_MODE;
      default: return 9'h000;
    endcase
  endfunction

  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // One bus cycle; a read sees the value before a same-cycle write
  task automatic bus(input logic w, r, input logic [6:0] a, input logic [8:0] d);
    @(posedge clk_sys);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 0;
    regRead <= 0;
    #1;
    cmp("rdValid", r, regRdValid);
    if (r) cmp("rdData", m[a], regRdData);
    if (w) m[a] = d & mask(a);
  endtask

  task automatic check_ctl();
    logic [5:0] lv;
    b = m[7'h2f];
    lv = m[7'h20][8] ? loopGain : m[7'h2d][5:0];
    col = frac441Clock ? 2 : m[7'h07][1];
    cmp("inv", m[7'h2c][1], invInputConnect);
    cmp("nonInv", m[7'h2c][0], noninvInputConnect);
    cmp("mid", !m[7'h2c][0], midRefToPositive);
    cmp("line", m[7'h2c][2], lineToAmpConnect);
    cmp("amp", m[7'h02][2], gainAmpEnable);
    cmp("lvl", lv, gainAmpLevel);
    cmp("qdb", 9'(3 * lv - 48), gainAmpQdb);
    cmp("zc", m[7'h2d][7], gainZeroCross);
    cmp("boostEn", m[7'h02][4], boostStageEnable);
    cmp("lineDb", b[2:0] ? 5'(3 * b[2:0] - 15) : 5'h00, lineBoostDb);
    cmp("lineOn", |b[2:0], lineBoostConnect);
    cmp("mute", !m[7'h2d][6], ampToMixerConnect);
    cmp("ampDb", b[8] ? 5'h14 : 5'h00, ampPathBoostDb);
    cmp("niDb", b[6:4] ? 5'(3 * b[6:4] - 15) : 5'h00, noninvBoostDb);
    cmp("niOn", |b[6:4], noninvBoostConnect);
    cmp("biasEn", m[7'h01][4], capsuleBiasEnable);
    cmp("biasLvl", bias[{m[7'h3a][4], m[7'h2c][8:7]}], biasRatioMilli);
    cmp("conv", m[7'h02][0], converterEnable);
    cmp("osr", m[7'h0e][3] ? 8'h80 : 8'h40, oversampleRatio);
    cmp("hpEn", m[7'h0e][8], highpassEnable);
    cmp("hpOrd", m[7'h0e][7], highpassSecondOrder);
    cmp("hpHz", hz[col][m[7'h0e][6:4]], highpassCutoffHz);
  endtask

  task automatic smp(input logic [23:0] d);
    @(posedge clk_sys);
    sampleIn <= d;
    sampleInValid <= 1;
    @(posedge clk_sys);
    sampleInValid <= 0;
    #1;
    cmp("outValid", m[7'h02][0], sampleOutValid);
    if (m[7'h02][0]) cmp("sample", m[7'h0e][0] ? (d == 24'h800000 ? 24'h7fffff : -d) : d, sampleOut);
  endtask

  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, random register traffic, then the sample path
  initial begin
    col = $urandom(51741);
    m = '{default: 9'h000};
    m[7'h20] = 9'h038;
    m[7'h2d] = 9'h010;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1;
    foreach (ofs[i]) bus(0, 1, ofs[i], 0);
    check_ctl();
    repeat (300) begin
      @(posedge clk_sys);
      loopGain <= 6'($urandom);
      frac441Clock <= 1'($urandom);
      bus(1, 0, ofs[$urandom % 10], 9'($urandom));
      check_ctl();
    end
    bus(1, 1, 7'h2d, 9'h1ff);
    bus(1, 0, 7'h02, 9'h001);
    bus(1, 0, 7'h0e, 9'h001);
    bus(0, 1, 7'h2d, 0);
    smp(24'h000005);
    smp(24'h800000);
    bus(1, 0, 7'h0e, 0);
    smp(24'($urandom));
    bus(1, 0, 7'h02, 0);
    bus(0, 0, 0, 0);
    smp(24'h123456);
    final_report();
  end
endmodule // tb
